// [design/scb_pkg.sv]
// Notes on behaviour
// - Trap pushes PC then flags, loads vector, sets mask; 14 or 16 states.
// - Exception return pops flags first, then PC; all flags take popped value.
// - Sleep enters power-down, leaves flags alone, takes 2 states.
// - Flag load reads byte at base into flags, then base plus 2.
// - Flag store: base minus 2, then writes flags; flags never change.
// - Byte block move copies, bumps pointers, counts 8-bit count down to zero.
// - Word block move uses 16-bit count, otherwise like byte move, flags kept.
// - 16-bit arithmetic: half-carry is carry or borrow out of bit 11.
// - 32-bit arithmetic: half-carry is carry or borrow out of bit 27.
// - Extended add/subtract: zero flag kept on zero result, else cleared.
// - Decimal adjust: carry set on adjust carry, otherwise kept.
// - Moves synchronised to slow peripheral strobe take variable time.
// - Signed divide: negative flag follows sign of divisor.
// - Divide: zero flag set when divisor is zero, else cleared.
// - Unsigned divide: negative flag follows quotient sign bit.
`default_nettype none
package scb_pkg;
	localparam logic [7:0] SCB_OFF_CMD = 8'h00;
	localparam logic [7:0] SCB_OFF_CCR = 8'h04;
	localparam logic [7:0] SCB_OFF_PC = 8'h08;
	localparam logic [7:0] SCB_OFF_SP = 8'h0C;
	localparam logic [7:0] SCB_OFF_BASE = 8'h10;
	localparam logic [7:0] SCB_OFF_COUNT = 8'h14;
	localparam logic [7:0] SCB_OFF_SRC = 8'h18;
	localparam logic [7:0] SCB_OFF_DST = 8'h1C;
	localparam logic [7:0] SCB_OFF_IMM = 8'h20;
	localparam logic [7:0] SCB_OFF_OPA = 8'h24;
	localparam logic [7:0] SCB_OFF_OPB = 8'h28;
	localparam logic [7:0] SCB_OFF_RESULT = 8'h2C;
	localparam logic [7:0] SCB_OFF_MADDR = 8'h30;
	localparam logic [7:0] SCB_OFF_MDATA = 8'h34;
	localparam logic [7:0] SCB_OFF_MODE = 8'h38;

	localparam int SCB_F_I = 7;
	localparam int SCB_F_H = 5;
	localparam int SCB_F_N = 3;
	localparam int SCB_F_Z = 2;
	localparam int SCB_F_V = 1;
	localparam int SCB_F_C = 0;
	localparam int SCB_ST_BUSY = 0;
	localparam int SCB_ST_SLEEP = 1;
	localparam int SCB_ST_ADV = 2;

	localparam logic [7:0] SCB_CCR_RST = 8'h80;
	localparam logic [31:0] SCB_WORD = 32'h0000_0002;
	localparam logic [31:0] SCB_LONG = 32'h0000_0004;
	localparam logic [31:0] SCB_ONE = 32'h0000_0001;

	// Each count is the number of states minus one.
	localparam logic [4:0] SCB_N_TRAP_NRM = 5'h0D;
	localparam logic [4:0] SCB_N_TRAP_ADV = 5'h0F;
	localparam logic [4:0] SCB_N_RTE = 5'h09;
	localparam logic [4:0] SCB_N_SHORT = 5'h01;
	localparam logic [4:0] SCB_N_MEM = 5'h07;
	localparam logic [4:0] SCB_N_BYTE = 5'h03;

	typedef enum logic [3:0] {
		SCB_NOP = 4'h0, SCB_TRAP = 4'h1, SCB_RTE = 4'h2, SCB_SLEEP = 4'h3,
		SCB_LDC_INC = 4'h4, SCB_STC_DEC = 4'h5, SCB_ANDI = 4'h6,
		SCB_ORI = 4'h7, SCB_XORI = 4'h8, SCB_MOVB = 4'h9, SCB_MOVW = 4'hA,
		SCB_ALU = 4'hB
	} scb_cmd_type;

	typedef enum logic [3:0] {
		SCB_ADD16 = 4'h0, SCB_SUB16 = 4'h1, SCB_ADD32 = 4'h2,
		SCB_SUB32 = 4'h3, SCB_ADDX = 4'h4, SCB_SUBX = 4'h5, SCB_DAA = 4'h6,
		SCB_DIVU = 4'h7, SCB_DIVS = 4'h8
	} scb_alu_type;

	typedef enum logic [1:0] {
		SCB_IDLE = 2'h0, SCB_RUN = 2'h1, SCB_MOVE = 2'h3
	} scb_state_type;
endpackage
`default_nettype wire

// [design/scb_exec.sv]
`timescale 1ns/10ps
`default_nettype none
module scb_exec #(
	parameter int P_AW = 8,
	parameter logic [31:0] P_VEC_BASE = 32'h0000_0040
) (
	input wire logic hclk, // Bus clock.
	input wire logic hresetn, // Asynchronous reset, active low.
	input wire logic hsel, // Slave select.
	input wire logic [31:0] haddr, // Byte address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write when high.
	input wire logic [2:0] hsize, // Transfer size.
	input wire logic [31:0] hwdata, // Write data.
	input wire logic hready, // Bus ready in.
	output logic hreadyout, // Slave ready.
	output logic hresp, // Response, always OKAY.
	output logic [31:0] hrdata, // Read data.
	input wire logic eclk_stall, // Slow strobe not yet ready.
	output logic sleep_o, // Core in power-down.
	output logic busy_o // Instruction executing.
);
	import scb_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic [7:0] mem_q [0:(1<<P_AW)-1];
	logic [7:0] ccr_q;
	logic [31:0] pc_q, sp_q, base_q, src_q, dst_q, res_q, opa_q, opb_q;
	logic [31:0] maddr_q;
	logic [15:0] count_q;
	logic [7:0] imm_q;
	logic adv_q, sleep_q;
	scb_state_type state_q;
	scb_cmd_type op_q;
	logic [4:0] cnt_q;
	logic wr_q, rd_q;
	logic [7:0] wa_q;

	function automatic logic [7:0] rdb(input logic [31:0] a);
		rdb = mem_q[a[P_AW-1:0]];
	endfunction

	function automatic logic [31:0] rdpc(input logic [31:0] a,
			input logic adv);
		if (adv) begin
			rdpc = {rdb(a), rdb(a + SCB_ONE), rdb(a + SCB_WORD),
				rdb(a + SCB_WORD + SCB_ONE)};
		end else begin
			rdpc = {16'h0000, rdb(a), rdb(a + SCB_ONE)};
		end
	endfunction

	function automatic logic [4:0] states(input scb_cmd_type op,
			input logic adv);
		case (op)
			SCB_TRAP: states = adv ? SCB_N_TRAP_ADV : SCB_N_TRAP_NRM;
			SCB_RTE: states = SCB_N_RTE;
			SCB_LDC_INC: states = SCB_N_MEM;
			SCB_STC_DEC: states = SCB_N_MEM;
			SCB_MOVB: states = SCB_N_MEM;
			SCB_MOVW: states = SCB_N_MEM;
			default: states = SCB_N_SHORT;
		endcase
	endfunction

	// Returns the new flags above the 32-bit result.
	function automatic logic [39:0] alu(input logic [3:0] op,
			input logic [31:0] a, input logic [31:0] b,
			input logic [7:0] condition_flag_register);
		logic [7:0] f;
		logic [31:0] r;
		logic [32:0] s;
		logic [8:0] s8;
		logic [4:0] h4;
		logic [7:0] d;
		logic [15:0] q;
		logic signed [15:0] sa, sb, sq, sr;
		f = condition_flag_register;
		r = a;
		s = 33'h0_0000_0000;
		s8 = 9'h000;
		h4 = 5'h00;
		d = 8'h00;
		q = 16'h0000;
		sa = $signed(a[15:0]);
		sb = $signed({{8{b[7]}}, b[7:0]});
		sq = 16'sh0000;
		sr = 16'sh0000;
		case (op)
			SCB_ADD16, SCB_SUB16: begin
				if (op == SCB_ADD16) begin
					s = 33'(a[15:0]) + 33'(b[15:0]);
					f[SCB_F_H] = (13'(a[11:0]) + 13'(b[11:0])) > 13'h0FFF;
					f[SCB_F_V] = (a[15] == b[15]) && (s[15] != a[15]);
				end else begin
					s = 33'(a[15:0]) - 33'(b[15:0]);
					f[SCB_F_H] = a[11:0] < b[11:0];
					f[SCB_F_V] = (a[15] != b[15]) && (s[15] != a[15]);
				end
				r = 32'(s[15:0]);
				f[SCB_F_N] = s[15];
				f[SCB_F_Z] = s[15:0] == 16'h0000;
				f[SCB_F_C] = s[16];
			end
			SCB_ADD32, SCB_SUB32: begin
				if (op == SCB_ADD32) begin
					s = 33'(a) + 33'(b);
					f[SCB_F_H] = (29'(a[27:0]) + 29'(b[27:0])) > 29'h0FFF_FFFF;
					f[SCB_F_V] = (a[31] == b[31]) && (s[31] != a[31]);
				end else begin
					s = 33'(a) - 33'(b);
					f[SCB_F_H] = a[27:0] < b[27:0];
					f[SCB_F_V] = (a[31] != b[31]) && (s[31] != a[31]);
				end
				r = s[31:0];
				f[SCB_F_N] = s[31];
				f[SCB_F_Z] = s[31:0] == 32'h0000_0000;
				f[SCB_F_C] = s[32];
			end
			SCB_ADDX, SCB_SUBX: begin
				if (op == SCB_ADDX) begin
					s8 = 9'(a[7:0]) + 9'(b[7:0]) + 9'(condition_flag_register[SCB_F_C]);
					h4 = 5'(a[3:0]) + 5'(b[3:0]) + 5'(condition_flag_register[SCB_F_C]);
					f[SCB_F_V] = (a[7] == b[7]) && (s8[7] != a[7]);
				end else begin
					s8 = 9'(a[7:0]) - 9'(b[7:0]) - 9'(condition_flag_register[SCB_F_C]);
					h4 = 5'(a[3:0]) - 5'(b[3:0]) - 5'(condition_flag_register[SCB_F_C]);
					f[SCB_F_V] = (a[7] != b[7]) && (s8[7] != a[7]);
				end
				r = 32'(s8[7:0]);
				f[SCB_F_H] = h4[4];
				f[SCB_F_N] = s8[7];
				if (s8[7:0] != 8'h00) begin
					f[SCB_F_Z] = 1'b0;
				end
				f[SCB_F_C] = s8[8];
			end
			SCB_DAA: begin
				if (condition_flag_register[SCB_F_C] || a[7:0] > 8'h99) begin
					d = 8'h60;
					f[SCB_F_C] = 1'b1;
				end
				if (condition_flag_register[SCB_F_H] || a[3:0] > 4'h9) begin
					d = d | 8'h06;
				end
				s8 = 9'(a[7:0]) + 9'(d);
				r = 32'(s8[7:0]);
				f[SCB_F_N] = s8[7];
				f[SCB_F_Z] = s8[7:0] == 8'h00;
			end
			SCB_DIVU: begin
				if (b[7:0] != 8'h00) begin
					q = a[15:0] / 16'(b[7:0]);
					r = {16'h0000, 8'(a[15:0] % 16'(b[7:0])), q[7:0]};
				end
				f[SCB_F_N] = q[7];
				f[SCB_F_Z] = b[7:0] == 8'h00;
			end
			SCB_DIVS: begin
				if (b[7:0] != 8'h00) begin
					sq = sa / sb;
					sr = sa % sb;
					r = {16'h0000, sr[7:0], sq[7:0]};
				end
				f[SCB_F_N] = b[7];
				f[SCB_F_Z] = b[7:0] == 8'h00;
			end
			default: r = a;
		endcase
		alu = {f, r};
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic cmd_go, fin, copy, is_move, cnt_zero_next;
	logic [31:0] pcn, push_base, vec_addr;
	logic [15:0] count_next;
	logic [39:0] alu_out;

	assign cmd_go = wr_q && wa_q == SCB_OFF_CMD && state_q == SCB_IDLE &&
		!sleep_q;
	assign fin = state_q == SCB_RUN && cnt_q == 5'h00;
	assign copy = state_q == SCB_MOVE && cnt_q == 5'h00 &&
		!eclk_stall;
	assign is_move = op_q == SCB_MOVB || op_q == SCB_MOVW;
	assign pcn = adv_q ? SCB_LONG : SCB_WORD;
	assign push_base = sp_q - pcn;
	assign vec_addr = P_VEC_BASE + 32'(imm_q[1:0]) * pcn;
	assign count_next = op_q == SCB_MOVW ? count_q - 16'h0001 :
		{count_q[15:8], count_q[7:0] - 8'h01};
	assign cnt_zero_next = op_q == SCB_MOVW ? count_next == 16'h0000 :
		count_next[7:0] == 8'h00;
	assign alu_out = alu(imm_q[3:0], opa_q, opb_q, ccr_q);

	////////////////////////////////////////////////////////////////////////
	// Zero-wait slave: registers are updated in the data phase.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign busy_o = state_q != SCB_IDLE;
	assign sleep_o = sleep_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			wa_q <= 8'h00;
		end else if (hready) begin
			wr_q <= hsel && htrans[1] && hwrite;
			rd_q <= hsel && htrans[1] && !hwrite;
			wa_q <= {haddr[7:2], 2'h0};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			case ({haddr[7:2], 2'h0})
				SCB_OFF_CMD: hrdata <= {29'h0000_0000, adv_q, sleep_q,
					state_q != SCB_IDLE};
				SCB_OFF_CCR: hrdata <= {24'h00_0000, ccr_q};
				SCB_OFF_PC: hrdata <= pc_q;
				SCB_OFF_SP: hrdata <= sp_q;
				SCB_OFF_BASE: hrdata <= base_q;
				SCB_OFF_COUNT: hrdata <= {16'h0000, count_q};
				SCB_OFF_SRC: hrdata <= src_q;
				SCB_OFF_DST: hrdata <= dst_q;
				SCB_OFF_IMM: hrdata <= {24'h00_0000, imm_q};
				SCB_OFF_OPA: hrdata <= opa_q;
				SCB_OFF_OPB: hrdata <= opb_q;
				SCB_OFF_RESULT: hrdata <= res_q;
				SCB_OFF_MADDR: hrdata <= maddr_q;
				SCB_OFF_MDATA: hrdata <= {24'h00_0000, rdb(maddr_q)};
				SCB_OFF_MODE: hrdata <= {31'h0000_0000, adv_q};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer: counts the states of each instruction.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= SCB_IDLE;
			op_q <= SCB_NOP;
			cnt_q <= 5'h00;
		end else begin
			case (state_q)
				SCB_IDLE: begin
					if (cmd_go) begin
						op_q <= scb_cmd_type'(hwdata[3:0]);
						cnt_q <= states(scb_cmd_type'(hwdata[3:0]), adv_q);
						state_q <= SCB_RUN;
					end
				end
				SCB_RUN: begin
					if (cnt_q != 5'h00) begin
						cnt_q <= cnt_q - 5'h01;
					end else if (is_move && (op_q == SCB_MOVW ?
							count_q != 16'h0000 : count_q[7:0] != 8'h00)) begin
						cnt_q <= SCB_N_BYTE;
						state_q <= SCB_MOVE;
					end else begin
						state_q <= SCB_IDLE;
					end
				end
				SCB_MOVE: begin
					if (cnt_q != 5'h00) begin
						cnt_q <= cnt_q - 5'h01;
					end else if (copy) begin
						cnt_q <= SCB_N_BYTE;
						if (cnt_zero_next) begin
							state_q <= SCB_IDLE;
						end
					end
				end
				default: state_q <= SCB_IDLE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sleep_q <= 1'b0;
		end else if (fin && op_q == SCB_SLEEP) begin
			sleep_q <= 1'b1;
		end else if (wr_q && wa_q == SCB_OFF_CMD && sleep_q) begin
			sleep_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Architectural registers: the bus writes them only while idle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ccr_q <= SCB_CCR_RST;
			pc_q <= 32'h0000_0000;
			sp_q <= 32'h0000_0000;
			base_q <= 32'h0000_0000;
			count_q <= 16'h0000;
			src_q <= 32'h0000_0000;
			dst_q <= 32'h0000_0000;
			imm_q <= 8'h00;
			opa_q <= 32'h0000_0000;
			opb_q <= 32'h0000_0000;
			res_q <= 32'h0000_0000;
			maddr_q <= 32'h0000_0000;
			adv_q <= 1'b0;
		end else if (fin) begin
			case (op_q)
				SCB_NOP: pc_q <= pc_q + SCB_WORD;
				SCB_TRAP: begin
					sp_q <= push_base - SCB_WORD;
					pc_q <= rdpc(vec_addr, adv_q);
					ccr_q[SCB_F_I] <= 1'b1;
				end
				SCB_RTE: begin
					ccr_q <= rdb(sp_q);
					pc_q <= rdpc(sp_q + SCB_WORD, adv_q);
					sp_q <= sp_q + SCB_WORD + pcn;
				end
				SCB_LDC_INC: begin
					ccr_q <= rdb(base_q);
					base_q <= base_q + SCB_WORD;
				end
				SCB_STC_DEC: base_q <= base_q - SCB_WORD;
				SCB_ANDI: ccr_q <= ccr_q & imm_q;
				SCB_ORI: ccr_q <= ccr_q | imm_q;
				SCB_XORI: ccr_q <= ccr_q ^ imm_q;
				SCB_ALU: begin
					ccr_q <= alu_out[39:32];
					res_q <= alu_out[31:0];
				end
				default: ccr_q <= ccr_q;
			endcase
		end else if (copy) begin
			src_q <= src_q + SCB_ONE;
			dst_q <= dst_q + SCB_ONE;
			count_q <= count_next;
		end else if (wr_q && state_q == SCB_IDLE) begin
			case (wa_q)
				SCB_OFF_CCR: ccr_q <= hwdata[7:0];
				SCB_OFF_PC: pc_q <= hwdata;
				SCB_OFF_SP: sp_q <= hwdata;
				SCB_OFF_BASE: base_q <= hwdata;
				SCB_OFF_COUNT: count_q <= hwdata[15:0];
				SCB_OFF_SRC: src_q <= hwdata;
				SCB_OFF_DST: dst_q <= hwdata;
				SCB_OFF_IMM: imm_q <= hwdata[7:0];
				SCB_OFF_OPA: opa_q <= hwdata;
				SCB_OFF_OPB: opb_q <= hwdata;
				SCB_OFF_MADDR: maddr_q <= hwdata;
				SCB_OFF_MDATA: maddr_q <= maddr_q + SCB_ONE;
				SCB_OFF_MODE: adv_q <= hwdata[0];
				default: adv_q <= adv_q;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Memory: stack, vectors and block-move data share one byte array.
	always_ff @(posedge hclk) begin
		if (fin && op_q == SCB_TRAP) begin
			for (int i = 0; i < 4; i++) begin
				if (32'(i) < pcn) begin
					mem_q[P_AW'(push_base + 32'(i))] <=
						8'(pc_q >> (8 * (32'(pcn) - 32'(i) - 1)));
				end
			end
			mem_q[P_AW'(push_base - SCB_WORD)] <= ccr_q;
			mem_q[P_AW'(push_base - SCB_ONE)] <= ccr_q;
		end else if (fin && op_q == SCB_STC_DEC) begin
			mem_q[P_AW'(base_q - SCB_WORD)] <= ccr_q;
			mem_q[P_AW'(base_q - SCB_ONE)] <= ccr_q;
		end else if (copy) begin
			mem_q[P_AW'(dst_q)] <= rdb(src_q);
		end else if (wr_q && state_q == SCB_IDLE && wa_q == SCB_OFF_MDATA) begin
			mem_q[P_AW'(maddr_q)] <= hwdata[7:0];
		end
	end
endmodule
`default_nettype wire

// [tb/scb_strobe_model.sv]
`timescale 1ns/10ps
`default_nettype none
module scb_strobe_model (
	input wire logic hclk, // Core clock.
	input wire logic hresetn, // Reset, active low.
	input wire logic slow, // Stretch the strobe when high.
	output logic eclk_stall // High while the slow strobe is not ready.
);
	logic [1:0] phase_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end
	// When stretched, the strobe is ready only one state in four.
	assign eclk_stall = slow && (phase_q != 2'h3);
endmodule
`default_nettype wire

// [tb/scb_exec_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module scb_exec_checker
	import scb_pkg::*;
(
	input wire logic hclk, // Clock.
	input wire logic hresetn, // Reset, active low.
	input wire logic hsel, // Select.
	input wire logic [31:0] haddr, // Address.
	input wire logic [1:0] htrans, // Transfer type.
	input wire logic hwrite, // Write.
	input wire logic [31:0] hwdata, // Write data.
	input wire logic hready, // Ready.
	input wire logic eclk_stall, // Strobe stall.
	input wire logic sleep_o, // Power-down.
	input wire logic busy_o // Executing.
);
	logic wph_q, adv_q, cmdw, go;
	logic [7:0] wad_q, cnt_q;
	logic [3:0] cmd_q;
	logic [11:0] len_q;
	assign cmdw = wph_q && wad_q == SCB_OFF_CMD;
	assign go = cmdw && !busy_o && !sleep_o;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wph_q <= 1'b0;
			wad_q <= 8'h00;
		end else begin
			wph_q <= hsel && htrans[1] && hready && hwrite;
			wad_q <= haddr[7:0];
		end
	end
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			adv_q <= 1'b0;
			cnt_q <= 8'h00;
		end else if (wph_q && !busy_o) begin
			if (wad_q == SCB_OFF_MODE) adv_q <= hwdata[0];
			if (wad_q == SCB_OFF_COUNT) cnt_q <= hwdata[7:0];
		end else if ($fell(busy_o) &&
				cmd_q inside {SCB_MOVB, SCB_MOVW}) begin
			// A finished move leaves the byte count at zero.
			cnt_q <= 8'h00;
		end
	end
	// Busy span of the command last started.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_q <= 4'h0;
			len_q <= 12'h000;
		end else if (go) begin
			cmd_q <= hwdata[3:0];
			len_q <= 12'h000;
		end else if (busy_o) begin
			len_q <= len_q + 12'h001;
		end
	end
	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_nop;
		go && hwdata[3:0] == SCB_NOP |=> busy_o [*2] ##1 !busy_o;
	endproperty
	a_nop: assert property (p_nop) else $error("nop span wrong");
	property p_logic;
		go && hwdata[3:0] inside {SCB_ANDI, SCB_ORI, SCB_XORI}
			|=> busy_o [*2] ##1 !busy_o;
	endproperty
	a_logic: assert property (p_logic) else $error("flag op span");
	property p_sleep;
		go && hwdata[3:0] == SCB_SLEEP |=> busy_o [*2] ##1 (!busy_o && sleep_o);
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep entry");
	property p_sleep_hold;
		sleep_o |=> (sleep_o != $past(cmdw)) && !busy_o;
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("sleep hold");
	property p_trap;
		$fell(busy_o) && cmd_q == SCB_TRAP
			|-> len_q == (adv_q ? 12'h010 : 12'h00E);
	endproperty
	a_trap: assert property (p_trap) else $error("trap span wrong");
	property p_rte;
		$fell(busy_o) && cmd_q == SCB_RTE |-> len_q == 12'h00A;
	endproperty
	a_rte: assert property (p_rte) else $error("return span wrong");
	property p_ldc;
		$fell(busy_o) && cmd_q == SCB_LDC_INC |-> len_q == 12'h008;
	endproperty
	a_ldc: assert property (p_ldc) else $error("flag load span");
	property p_stc;
		$fell(busy_o) && cmd_q == SCB_STC_DEC |-> len_q == 12'h008;
	endproperty
	a_stc: assert property (p_stc) else $error("flag store span");
	property p_movb;
		$fell(busy_o) && cmd_q == SCB_MOVB
			|-> len_q >= 12'h008 + {2'h0, cnt_q, 2'h0};
	endproperty
	a_movb: assert property (p_movb) else $error("byte move too short");
	c_trap_adv: cover property (go && hwdata[3:0] == SCB_TRAP && adv_q);
	c_stall: cover property (busy_o && eclk_stall);
	c_wake: cover property (sleep_o && cmdw);
endmodule
bind scb_exec scb_exec_checker chk (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .eclk_stall(eclk_stall),
	.sleep_o(sleep_o), .busy_o(busy_o));
`default_nettype wire

// [tb/test_system_control_block_move_exec.sv]
`timescale 1ns/10ps
`default_nettype none
module test_system_control_block_move_exec;
	import scb_pkg::*;
	localparam logic [7:0] VB = 8'h40;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, h;
	logic slow, eclk_stall, sleep_o, busy_o, rdchk;
	logic [31:0] haddr, hwdata, hrdata, a, b;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] f, k;
	logic [63:0] nt;
	logic [63:0] notes[$];
	int miscompares, n_compared;
	assign hready = hreadyout;
	scb_exec #(.P_AW(8), .P_VEC_BASE(32'(VB))) DUT (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.eclk_stall(eclk_stall), .sleep_o(sleep_o), .busy_o(busy_o));
	scb_strobe_model strobe (.hclk(hclk), .hresetn(hresetn), .slow(slow),
		.eclk_stall(eclk_stall));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
		end
	endtask
	// One single transfer; for a read, d is the expected word under mask m.
	task automatic bus(input logic w, input logic [7:0] ad,
		input logic [31:0] d, input logic [31:0] m);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= 32'(ad);
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		rdchk <= !w;
		if (!w) notes.push_back({m, d & m});
		do @(posedge hclk); while (hready !== 1'b1);
		rdchk <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		bus(1'b1, ad, d, 32'h0000_0000);
	endtask
	task automatic rd(input logic [7:0] ad, input logic [31:0] e,
		input logic [31:0] m = 32'hFFFF_FFFF);
		bus(1'b0, ad, e, m);
	endtask
	task automatic run(input logic [3:0] c);
		int n;
		n = 0;
		wr(SCB_OFF_CMD, 32'(c));
		repeat (2) @(negedge hclk);
		while (busy_o !== 1'b0 && n < 3000) begin
			@(negedge hclk);
			n++;
		end
		if (n >= 3000) miscompares++;
		@(posedge hclk);
	endtask
	task automatic poke(input logic [7:0] ad, input logic [31:0] d);
		wr(SCB_OFF_MADDR, 32'(ad));
		for (int i = 3; i >= 0; i--) wr(SCB_OFF_MDATA, 32'(d[i*8 +: 8]));
	endtask
	task automatic peek(input logic [7:0] ad, input logic [7:0] e);
		wr(SCB_OFF_MADDR, 32'(ad));
		rd(SCB_OFF_MDATA, 32'(e));
	endtask
	task automatic alu(input scb_alu_type op, input logic [31:0] x, y,
		input logic [7:0] fi, m, fe);
		wr(SCB_OFF_CCR, 32'(fi));
		wr(SCB_OFF_IMM, 32'(op));
		wr(SCB_OFF_OPA, x);
		wr(SCB_OFF_OPB, y);
		run(SCB_ALU);
		rd(SCB_OFF_CCR, 32'(fe), 32'(m));
	endtask
	task automatic final_report();
		$display("compared %0d, mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Read results are compared against the oldest note.
	always @(posedge hclk) begin
		if (rdchk === 1'b1) begin
			nt = notes.pop_front();
			check(hrdata & nt[63:32], nt[31:0]);
			check(32'({hreadyout, hresp}), 32'h0000_0002);
		end
	end
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	initial begin
		#400000;
		miscompares++;
		final_report();
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		hwrite = 1'b0;
		haddr = 32'h0000_0000;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		rdchk = 1'b0;
		slow = 1'b0;
		miscompares = 0;
		n_compared = 0;
		void'($urandom(32'hca65_7fe8));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(SCB_OFF_CCR, 32'(SCB_CCR_RST));
		rd(8'h3C, 32'h0000_0000);
		f = 8'($urandom) & 8'h2F;
		wr(SCB_OFF_CCR, 32'(f));
		wr(SCB_OFF_PC, 32'h0000_0100);
		run(SCB_NOP);
		rd(SCB_OFF_PC, 32'h0000_0102);
		rd(SCB_OFF_CCR, 32'(f));
		for (int i = 0; i < 3; i++) begin
			f = 8'($urandom) & 8'hAF;
			k = 8'($urandom) & 8'hAF;
			wr(SCB_OFF_CCR, 32'(f));
			wr(SCB_OFF_IMM, 32'(k));
			run(4'(SCB_ANDI + i));
			rd(SCB_OFF_CCR, 32'(i == 0 ? f & k : i == 1 ? f | k : f ^ k));
		end
		$display("nop and flag ops done");
		wr(SCB_OFF_BASE, 32'h0000_0080);
		run(SCB_STC_DEC);
		rd(SCB_OFF_BASE, 32'h0000_007E);
		rd(SCB_OFF_CCR, 32'(f ^ k));
		peek(8'h7E, f ^ k);
		k = 8'($urandom) & 8'hAF;
		poke(8'h90, {k, k, 16'h0000});
		wr(SCB_OFF_BASE, 32'h0000_0090);
		run(SCB_LDC_INC);
		rd(SCB_OFF_CCR, 32'(k));
		rd(SCB_OFF_BASE, 32'h0000_0092);
		$display("flag load and store done");
		poke(VB + 8'h02, 32'h056A_0000);
		wr(SCB_OFF_SP, 32'h0000_00F0);
		wr(SCB_OFF_PC, 32'h0000_1234);
		wr(SCB_OFF_IMM, 32'h0000_0001);
		f = 8'($urandom) & 8'h2F;
		wr(SCB_OFF_CCR, 32'(f));
		run(SCB_TRAP);
		rd(SCB_OFF_PC, 32'h0000_056A);
		rd(SCB_OFF_CCR, 32'(f | 8'h80));
		rd(SCB_OFF_SP, 32'h0000_00EC);
		peek(8'hEE, 8'h12);
		peek(8'hEC, f);
		wr(SCB_OFF_CCR, 32'h0000_0025);
		run(SCB_RTE);
		rd(SCB_OFF_CCR, 32'(f));
		rd(SCB_OFF_PC, 32'h0000_1234);
		rd(SCB_OFF_SP, 32'h0000_00F0);
		$display("trap and return done");
		run(SCB_SLEEP);
		rd(SCB_OFF_CMD, 32'h0000_0002);
		rd(SCB_OFF_CCR, 32'(f));
		wr(SCB_OFF_CMD, 32'(SCB_NOP));
		rd(SCB_OFF_CMD, 32'h0000_0000);
		rd(SCB_OFF_PC, 32'h0000_1234);
		wr(SCB_OFF_MODE, 32'h0000_0001);
		poke(VB, 32'h0000_0ABC);
		wr(SCB_OFF_IMM, 32'h0000_0000);
		run(SCB_TRAP);
		rd(SCB_OFF_PC, 32'h0000_0ABC);
		rd(SCB_OFF_SP, 32'h0000_00EA);
		wr(SCB_OFF_MODE, 32'h0000_0000);
		$display("sleep and advanced trap done");
		a = $urandom;
		poke(8'h20, a);
		poke(8'h60, 32'h0000_0000);
		wr(SCB_OFF_COUNT, 32'h0000_0103);
		wr(SCB_OFF_SRC, 32'h0000_0020);
		wr(SCB_OFF_DST, 32'h0000_0060);
		slow <= 1'($urandom) | 1'b1;
		run(SCB_MOVB);
		rd(SCB_OFF_COUNT, 32'h0000_0100);
		rd(SCB_OFF_DST, 32'h0000_0063);
		peek(8'h62, a[15:8]);
		peek(8'h63, 8'h00);
		slow <= 1'b0;
		run(SCB_MOVB);
		rd(SCB_OFF_SRC, 32'h0000_0023);
		wr(SCB_OFF_COUNT, 32'h0000_0002);
		wr(SCB_OFF_DST, 32'h0000_0070);
		wr(SCB_OFF_CCR, 32'(f));
		run(SCB_MOVW);
		rd(SCB_OFF_COUNT, 32'h0000_0000);
		peek(8'h70, a[7:0]);
		rd(SCB_OFF_CCR, 32'(f));
		$display("block moves done");
		for (int i = 0; i < 4; i++) begin
			a = $urandom;
			b = $urandom;
			h = i == 0 ? 13'(a[11:0]) + 13'(b[11:0]) > 13'h0FFF :
				i == 1 ? a[11:0] < b[11:0] :
				i == 2 ? 29'(a[27:0]) + 29'(b[27:0]) > 29'h0FFF_FFFF :
				a[27:0] < b[27:0];
			alu(scb_alu_type'(i), a, b, 8'h00, 8'h20, {2'b00, h, 5'h00});
		end
		alu(SCB_ADDX, 32'h10, 32'hF0, 8'h04, 8'h04, 8'h04);
		alu(SCB_ADDX, 32'h01, 32'h01, 8'h04, 8'h04, 8'h00);
		alu(SCB_SUBX, 32'h05, 32'h05, 8'h00, 8'h04, 8'h00);
		alu(SCB_DAA, 32'h9A, 32'h00, 8'h00, 8'h01, 8'h01);
		alu(SCB_DAA, 32'h12, 32'h00, 8'h01, 8'h01, 8'h01);
		alu(SCB_DAA, 32'h12, 32'h00, 8'h00, 8'h01, 8'h00);
		alu(SCB_DIVS, 32'h10, 32'h80, 8'h00, 8'h0C, 8'h08);
		alu(SCB_DIVS, 32'h10, 32'h05, 8'h00, 8'h08, 8'h00);
		alu(SCB_DIVU, 32'h0100, 32'h02, 8'h00, 8'h0C, 8'h08);
		rd(SCB_OFF_RESULT, 32'h0000_0080);
		alu(SCB_DIVU, 32'h0100, 32'h04, 8'h00, 8'h08, 8'h00);
		alu(SCB_DIVU, 32'h0100, 32'h00, 8'h00, 8'h04, 8'h04);
		$display("arithmetic flags done");
		final_report();
	end
endmodule
`default_nettype wire
